// file: acbc_pkg.sv
package acbc_pkg;
    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 10;
    localparam int          MAX_DEPTH    = 1024;
    localparam logic [1:0]  DEPTH_BYPASS = 2'h0;
    localparam logic [1:0]  DEPTH_256    = 2'h1;
    localparam logic [1:0]  DEPTH_512    = 2'h2;
    localparam logic [1:0]  DEPTH_1024   = 2'h3;
    localparam logic [10:0] COUNT_256    = 11'h100;
    localparam logic [10:0] COUNT_512    = 11'h200;
    localparam logic [10:0] COUNT_1024   = 11'h400;
    localparam int          SYNC_STAGES  = 2;
    localparam int          RESET_MIN_CYCLES = 4;
    localparam logic        EMPTY_RESET  = 1'b1;
    localparam logic        FULL_RESET   = 1'b0;
    typedef enum logic [1:0]
    {
        ACBC_IDLE  = 2'b00,
        ACBC_WRITE = 2'b01,
        ACBC_READY = 2'b11,
        ACBC_READ  = 2'b10
    } acbc_state_type;
endpackage

// file: acbc_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface acbc_sync_if;
    logic raw;
    logic synced;
    modport owner (output raw, input synced);
    modport sync  (input raw, output synced);
endinterface
`default_nettype wire

// file: acbc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module acbc_sync
(
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    acbc_sync_if.sync   port
);
    logic stage1_reg;
    logic stage2_reg;
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= port.raw;
            stage2_reg <= stage1_reg;
        end
    end
    assign port.synced = stage2_reg;
endmodule
`default_nettype wire

// file: acbc_top.sv
`timescale 1ns/10ps
`default_nettype none
module acbc_top
#(
    parameter int DEPTH = acbc_pkg::MAX_DEPTH
)
(
    // clock and reset
    input  wire logic                        I_CLOCK,
    input  wire logic                        I_RESET,
    // converter samples
    input  wire logic [acbc_pkg::DATA_W-1:0] I_SAMPLE,
    // buffer control pins
    input  wire logic                        I_WRITE_ENABLE,
    input  wire logic                        I_READ_ENABLE,
    input  wire logic                        I_READ_CLOCK,
    input  wire logic                        I_AUTO_STOP_WRITE,
    input  wire logic                        I_BUFFER_DEPTH_SEL_LO,
    input  wire logic                        I_BUFFER_DEPTH_SEL_HI,
    // output control pins
    input  wire logic                        I_EDGE_SELECT_IN,
    input  wire logic                        I_TEST_MODE,
    input  wire logic                        I_OUTPUT_ENABLE,
    input  wire logic [acbc_pkg::DATA_W-1:0] I_TEST_PATTERN,
    // data port
    output logic      [acbc_pkg::DATA_W-1:0] O_DATA,
    output logic      [acbc_pkg::DATA_W-1:0] O_DATA_OE,
    output logic                             O_DATA_VALID_STROBE,
    output logic                             O_DATA_VALID_STROBE_OE,
    // flags
    output logic                             O_EMPTY_FLAG,
    output logic                             O_FULL_FLAG,
    output logic                             O_SAMPLE_INDICATOR_OUT
);
    localparam int AW = acbc_pkg::ADDR_W;
    localparam int DW = acbc_pkg::DATA_W;

    // pin synchronisers for the seven control pins; depth select, sample and pattern inputs are used unsynchronised
    acbc_sync_if wen_if ();
    acbc_sync_if ren_if ();
    acbc_sync_if rclk_if ();
    acbc_sync_if asw_if ();
    acbc_sync_if edge_if ();
    acbc_sync_if test_if ();
    acbc_sync_if oe_if ();
    assign wen_if.raw  = I_WRITE_ENABLE;
    assign ren_if.raw  = I_READ_ENABLE;
    assign rclk_if.raw = I_READ_CLOCK;
    assign asw_if.raw  = I_AUTO_STOP_WRITE;
    assign edge_if.raw = I_EDGE_SELECT_IN;
    assign test_if.raw = I_TEST_MODE;
    assign oe_if.raw   = I_OUTPUT_ENABLE;
    acbc_sync u_wen  (.i_clk(I_CLOCK), .i_rst(I_RESET), .port(wen_if));
    acbc_sync u_ren  (.i_clk(I_CLOCK), .i_rst(I_RESET), .port(ren_if));
    acbc_sync u_rclk (.i_clk(I_CLOCK), .i_rst(I_RESET), .port(rclk_if));
    acbc_sync u_asw  (.i_clk(I_CLOCK), .i_rst(I_RESET), .port(asw_if));
    acbc_sync u_edge (.i_clk(I_CLOCK), .i_rst(I_RESET), .port(edge_if));
    acbc_sync u_test (.i_clk(I_CLOCK), .i_rst(I_RESET), .port(test_if));
    acbc_sync u_oe   (.i_clk(I_CLOCK), .i_rst(I_RESET), .port(oe_if));

    // storage, sized to the largest selectable depth
    logic [DW-1:0] mem [0:DEPTH-1];

    logic [AW-1:0]   wr_ptr_reg;
    logic [AW-1:0]   rd_ptr_reg;
    logic [AW:0]     fill_reg;
    logic            rclk_d_reg;
    logic            empty_reg;
    logic            full_reg;
    logic            stopped_reg;
    logic            wen_d_reg;
    logic            strobe_reg;
    logic [DW-1:0]   data_reg;
    logic [DW-1:0]   sample_reg;
    logic            oe_reg;
    logic            indicator_reg;
    acbc_pkg::acbc_state_type state_reg;
    acbc_pkg::acbc_state_type state_next;

    // mode decode
    wire [1:0] depth_sel = {I_BUFFER_DEPTH_SEL_HI, I_BUFFER_DEPTH_SEL_LO};
    wire       bypass    = (depth_sel == acbc_pkg::DEPTH_BYPASS);
    wire [AW:0] cap_count =
        (depth_sel == acbc_pkg::DEPTH_256) ? acbc_pkg::COUNT_256 :
        (depth_sel == acbc_pkg::DEPTH_512) ? acbc_pkg::COUNT_512 :
                                             acbc_pkg::COUNT_1024;
    wire       test_mode = test_if.synced;
    // test mode hands edge selection to the auto-stop pin
    wire       edge_sel  = test_mode ? asw_if.synced : edge_if.synced;
    wire       wen_s     = wen_if.synced & ~bypass;
    // write always wins over read
    wire       ren_s     = ren_if.synced & ~wen_s & ~bypass;
    wire       rclk_rise = rclk_if.synced & ~rclk_d_reg;
    wire       at_full   = (fill_reg == cap_count);
    // auto-stop only meaningful while writing
    wire       wr_block  = at_full & asw_if.synced & ~test_mode;
    wire       wr_start  = wen_s & ~wen_d_reg;
    wire       do_write  = wen_s & ~wr_start & ~wr_block;
    wire       do_read   = ren_s & rclk_rise & ~empty_reg
                           & (state_reg == acbc_pkg::ACBC_READ);
    wire       wrap_ptr  = (wr_ptr_reg == cap_count[AW-1:0] - 1'b1) | (cap_count == acbc_pkg::COUNT_1024
                           && wr_ptr_reg == {AW{1'b1}});
    wire [AW-1:0] wr_ptr_inc = wrap_ptr ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
    wire [AW-1:0] rd_ptr_inc = (rd_ptr_reg == cap_count[AW-1:0] - 1'b1) | (cap_count == acbc_pkg::COUNT_1024
                           && rd_ptr_reg == {AW{1'b1}}) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
    // overwrite at full keeps the fill count pinned
    wire [AW:0] fill_next = do_write ? (at_full ? fill_reg : fill_reg + 1'b1)
                          : do_read  ? fill_reg - 1'b1 : fill_reg;
    wire       idle_level = ~edge_sel;
    wire       drive_on   = oe_if.synced | test_mode;

    // phase sequencing
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            acbc_pkg::ACBC_IDLE:
                if (wen_s)
                    state_next = acbc_pkg::ACBC_WRITE;
            acbc_pkg::ACBC_WRITE:
                if (!wen_s)
                    state_next = at_full ? acbc_pkg::ACBC_READY : acbc_pkg::ACBC_IDLE;
            acbc_pkg::ACBC_READY:
                if (wen_s)
                    state_next = acbc_pkg::ACBC_WRITE;
                else if (ren_s)
                    state_next = acbc_pkg::ACBC_READ;
            acbc_pkg::ACBC_READ:
                if (wen_s)
                    state_next = acbc_pkg::ACBC_WRITE;
                else if (empty_reg)
                    state_next = acbc_pkg::ACBC_IDLE;
            default:
                state_next = acbc_pkg::ACBC_IDLE;
        endcase
        if (bypass)
            state_next = acbc_pkg::ACBC_IDLE;
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (do_write)
            mem[wr_ptr_reg] <= I_SAMPLE;
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (I_RESET)
        begin
            state_reg   <= acbc_pkg::ACBC_IDLE;
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            fill_reg    <= '0;
            empty_reg   <= acbc_pkg::EMPTY_RESET;
            full_reg    <= acbc_pkg::FULL_RESET;
            rclk_d_reg  <= 1'b0;
            wen_d_reg   <= 1'b0;
            stopped_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            rclk_d_reg  <= rclk_if.synced;
            wen_d_reg   <= wen_s;
            stopped_reg <= wr_block;
            if (wr_start)
            begin
                // internal reset of both counters on each new write phase
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                fill_reg   <= '0;
                empty_reg  <= 1'b1;
                full_reg   <= 1'b0;
            end
            else
            begin
                fill_reg   <= fill_next;
                if (do_write)
                    wr_ptr_reg <= wr_ptr_inc;
                if (do_read)
                    rd_ptr_reg <= rd_ptr_inc;
                empty_reg  <= ~bypass & (fill_next == '0);
                full_reg   <= ~bypass & (fill_next == cap_count);
            end
        end
    end

    // output stage; bypass runs at half the sample rate, buffered follows read clock
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RESET)
        begin
            data_reg      <= '0;
            strobe_reg    <= 1'b0;
            oe_reg        <= 1'b0;
            sample_reg    <= '0;
            indicator_reg <= 1'b0;
        end
        else
        begin
            oe_reg        <= drive_on;
            sample_reg    <= I_SAMPLE;
            indicator_reg <= wen_s & ~stopped_reg;
            if (bypass)
            begin
                // strobe runs continuously, data moves on the selected edge
                strobe_reg <= ~strobe_reg;
                if (strobe_reg != edge_sel)
                    data_reg <= sample_reg;
            end
            else if (do_read)
            begin
                data_reg   <= mem[rd_ptr_reg];
                strobe_reg <= edge_sel;
            end
            else if (ren_s && state_reg == acbc_pkg::ACBC_READ && !empty_reg && !rclk_if.synced)
                strobe_reg <= idle_level;
            else if (state_reg != acbc_pkg::ACBC_READ || empty_reg || !ren_s)
            begin
                data_reg   <= {DW{idle_level}};
                strobe_reg <= idle_level;
            end
            if (test_mode && !bypass && rclk_rise)
            begin
                data_reg   <= I_TEST_PATTERN;
                strobe_reg <= edge_sel;
            end
        end
    end

    assign O_DATA                 = data_reg;
    assign O_DATA_OE              = {DW{oe_reg}};
    assign O_DATA_VALID_STROBE    = strobe_reg;
    assign O_DATA_VALID_STROBE_OE = oe_reg;
    assign O_EMPTY_FLAG           = empty_reg;
    assign O_FULL_FLAG            = full_reg;
    assign O_SAMPLE_INDICATOR_OUT = indicator_reg;
endmodule
`default_nettype wire

// file: acbc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module acbc_monitor
(
    // watched pins
    input wire logic       I_CLOCK, I_RESET, I_WRITE_ENABLE, I_READ_ENABLE,
    input wire logic       I_BUFFER_DEPTH_SEL_LO, I_BUFFER_DEPTH_SEL_HI,
    input wire logic       I_EDGE_SELECT_IN, I_TEST_MODE, I_OUTPUT_ENABLE,
    input wire logic [7:0] O_DATA, O_DATA_OE,
    input wire logic       O_DATA_VALID_STROBE, O_DATA_VALID_STROBE_OE, O_EMPTY_FLAG, O_FULL_FLAG
);
    wire logic byp  = !I_BUFFER_DEPTH_SEL_LO && !I_BUFFER_DEPTH_SEL_HI;
    wire logic strb = O_DATA_VALID_STROBE;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET);
    AST_RESET_FLAGS: assert property (disable iff (1'b0) I_RESET |=> O_EMPTY_FLAG && !O_FULL_FLAG)
        else $error("flags wrong after reset");
    AST_BYPASS_FLAGS: assert property ((byp && !I_RESET) |=> !O_EMPTY_FLAG && !O_FULL_FLAG)
        else $error("flags set in bypass");
    // two sync stages plus the output register: the drivers follow the pins after three edges
    AST_OE_OFF: assert property ((!I_OUTPUT_ENABLE && !I_TEST_MODE) [*4] |-> !O_DATA_OE && !O_DATA_VALID_STROBE_OE)
        else $error("drivers on with output enable low");
    AST_TEST_DRIVES: assert property (I_TEST_MODE [*4] |-> O_DATA_OE == 8'hFF && O_DATA_VALID_STROBE_OE)
        else $error("drivers off in test mode");
    AST_BYPASS_TOGGLE: assert property ((byp && !I_TEST_MODE) [*4] |-> strb != $past(strb))
        else $error("strobe stalled in bypass");
    // edge select resets low in its synchroniser, so the first three edges after release are left out
    AST_BYPASS_EDGE: assert property ((byp && !I_TEST_MODE && !I_RESET) [*4] ##0 $changed(O_DATA)
        |-> strb == I_EDGE_SELECT_IN)
        else $error("data moved on wrong strobe edge");
    AST_WRITE_QUIET: assert property ((I_WRITE_ENABLE && !byp) [*6] |-> $stable(strb) && $stable(O_DATA))
        else $error("output moved during write");
    AST_FILL_CLEARS_EMPTY: assert property ((I_WRITE_ENABLE && !byp) [*6] |-> !O_EMPTY_FLAG)
        else $error("empty still high while writing");
    AST_IDLE_LEVEL: assert property ((O_EMPTY_FLAG && !I_READ_ENABLE && !byp && !I_TEST_MODE) [*4]
        |-> O_DATA == {8{!I_EDGE_SELECT_IN}} && strb == !I_EDGE_SELECT_IN)
        else $error("idle level wrong");
    COV_FULL: cover property ($rose(O_FULL_FLAG));
    COV_EMPTY: cover property ($rose(O_EMPTY_FLAG));
    COV_BYPASS: cover property (byp && $changed(strb));
endmodule
bind acbc_top acbc_monitor mon (.*);
`default_nettype wire

// file: acbc_reader.sv
`timescale 1ns/10ps
`default_nettype none
module acbc_reader
(
    // control from bench
    input  wire logic i_go,
    input  wire logic i_wen,
    // read side pins
    output logic      o_rclk,
    output logic      o_ren
);
    logic ren_reg;
    assign o_ren = ren_reg && !i_wen;
    initial
    begin
        o_rclk  = 1'b0;
        ren_reg = 1'b0;
    end
    // clock parked low between reads, phase unrelated to the sample clock
    always
    begin
        wait (i_go);
        ren_reg = 1'b1;
        #3;
        while (i_go)
        begin
            #80 o_rclk = 1'b1;
            #80 o_rclk = 1'b0;
        end
        ren_reg = 1'b0;
    end
endmodule
`default_nettype wire

// file: adc_capture_buffer_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_capture_buffer_control_bench;
    logic       clk, rst, wen, auto_stop_write, slo, shi, edg, tst, oe, go, cap, prev;
    logic       rclk, ren, stb, stboe, ef, ff, sio;
    logic [7:0] smp, dat, doe, last;
    int         error_cnt, n_tests, cyc, n_got, seq_bad;
    acbc_top dut
    (
        .I_CLOCK(clk), .I_RESET(rst), .I_SAMPLE(smp), .I_WRITE_ENABLE(wen), .I_READ_ENABLE(ren),
        .I_READ_CLOCK(rclk), .I_AUTO_STOP_WRITE(auto_stop_write), .I_BUFFER_DEPTH_SEL_LO(slo), .I_BUFFER_DEPTH_SEL_HI(shi),
        .I_EDGE_SELECT_IN(edg), .I_TEST_MODE(tst), .I_OUTPUT_ENABLE(oe), .I_TEST_PATTERN(8'h5A),
        .O_DATA(dat), .O_DATA_OE(doe), .O_DATA_VALID_STROBE(stb), .O_DATA_VALID_STROBE_OE(stboe),
        .O_EMPTY_FLAG(ef), .O_FULL_FLAG(ff), .O_SAMPLE_INDICATOR_OUT(sio)
    );
    acbc_reader rdr (.i_go(go), .i_wen(wen), .o_rclk(rclk), .o_ren(ren));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        smp <= smp + 8'h01;
        cyc <= cyc + 1;
    end
    // falling edge sampling keeps clear of the launching edge
    always @(negedge clk)
    begin
        prev <= stb;
        if (cap && stb === edg && prev !== edg)
        begin
            seq_bad <= seq_bad + ((n_got > 0 && dat !== last + 8'h01) ? 1 : 0);
            last <= dat;
            n_got <= n_got + 1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic waitv(input logic w, input logic v, input int lim);
        for (int k = 0; (w ? ff : ef) !== v && k < lim; k++)
            @(negedge clk);
        chk("flag wait", v, w ? ff : ef);
    endtask
    task automatic setup(input logic [1:0] sel, input logic e);
        @(posedge clk);
        {shi, slo} <= sel;
        edg <= e;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("reset empty", 1'b1, ef);
        chk("reset full", 1'b0, ff);
        @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic fill(input int depth);
        int t0;
        @(posedge clk);
        wen <= 1'b1;
        waitv(1'b0, 1'b0, 20);
        chk("indicator writing", 1'b1, sio);
        t0 = cyc;
        waitv(1'b1, 1'b1, depth + 20);
        chk("fill cycles", depth - 1, cyc - t0);
        repeat (19) @(posedge clk);
        @(negedge clk);
        chk("indicator halted", 1'b0, sio);
        @(posedge clk);
        wen <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic drain(input int depth);
        n_got = 0;
        seq_bad = 0;
        cap = 1'b1;
        @(posedge clk);
        go <= 1'b1;
        waitv(1'b0, 1'b1, depth * 17 + 50);
        @(posedge clk);
        go <= 1'b0;
        repeat (40) @(posedge clk);
        cap = 1'b0;
        @(negedge clk);
        chk("bytes read", depth, n_got);
        chk("order breaks", 0, seq_bad);
        chk("idle data", 8'hFF, dat);
        chk("idle strobe", 1'b1, stb);
        chk("full after read", 1'b0, ff);
    endtask
    task automatic t_bypass_oe();
        int n;
        logic s0;
        n = 0;
        setup(2'h0, 1'b1);
        wen <= 1'b1;
        go <= 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            s0 = stb;
            @(negedge clk);
            n += (stb !== s0) ? 1 : 0;
        end
        chk("bypass toggles", 20, n);
        chk("bypass flags", 2'h0, {ef, ff});
        @(posedge clk);
        {wen, go, oe} <= 3'h0;
        repeat (4) @(negedge clk);
        chk("oe off", 9'h000, {doe, stboe});
        @(posedge clk);
        tst <= 1'b1;
        repeat (4) @(negedge clk);
        chk("test drive", 9'h1FF, {doe, stboe});
        @(posedge clk);
        {tst, oe} <= 2'h1;
    endtask
    task automatic t_abort();
        int k;
        setup(2'h1, 1'b0);
        fill(256);
        cap = 1'b1;
        @(posedge clk);
        go <= 1'b1;
        repeat (80) @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        k = n_got;
        chk("abort empty", 1'b1, ef);
        repeat (100) @(posedge clk);
        chk("reads after abort", k, n_got);
        go <= 1'b0;
        cap = 1'b0;
    endtask
    // buffered test mode: one pattern byte per read clock rise, auto-stop pin picks the edge
    task automatic t_pattern();
        int n;
        n = 0;
        setup(2'h1, 1'b0);
        tst <= 1'b1;
        repeat (4) @(posedge clk);
        go <= 1'b1;
        repeat (80)
        begin
            @(negedge clk);
            n += (dat === 8'h5A && stb === 1'b1) ? 1 : 0;
        end
        chk("pattern bytes", 5, n);
        chk("pattern idle", 9'h000, {dat, stb});
        @(posedge clk);
        {tst, go} <= 2'h0;
        repeat (20) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        {rst, wen, auto_stop_write, slo, shi, edg, tst, oe, go, cap} = 10'h284;
        {smp, cyc, error_cnt, n_tests, prev} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_bypass_oe();
        for (int i = 1; i < 4; i++)
        begin
            setup(i[1:0], 1'b0);
            fill(128 << i);
            drain(128 << i);
        end
        t_pattern();
        t_abort();
        wrap_up();
    end
    initial
    begin
        #1_000_000;
        error_cnt++;
        wrap_up();
    end
endmodule
`default_nettype wire
